// [hw/aie_pkg.sv]
// shared constants and types for the add instruction execute block
package aie_pkg;
    // core clock rate
    localparam int unsigned CLK_HZ = 50_000_000;
    // core clock period in ns
    localparam int unsigned CLK_PERIOD_NS = 20;
    // core clock cycles per quarter-cycle enable
    localparam int unsigned QTR_DIV = 1;

    // widths of data, pointers and bank select
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 14;
    localparam int unsigned BANK_W = 6;
    localparam int unsigned PTR_CNT = 3;

    // upper byte of the literal-to-accumulator add (nibbles 0000 1111)
    localparam logic [7:0] OPC_LIT_ACC = 8'h0F;
    // upper byte of the literal-to-pointer add (nibbles 1110 1000)
    localparam logic [7:0] OPC_LIT_PTR = 8'hE8;
    // top six bits of the accumulator-to-register add (001001)
    localparam logic [5:0] OPC_ACC_REG = 6'h09;

    // instruction word field positions
    localparam int unsigned DEST_BIT = 9;
    localparam int unsigned BANK_BIT = 8;
    localparam int unsigned PSEL_LSB = 6;
    localparam logic [1:0] PSEL_NONE = 2'h3;
    // pointer used as base in indexed literal offset mode
    localparam int unsigned IDX_PTR = 2;

    // highest register operand handled by indexed or low access addressing
    localparam logic [7:0] LOW_ACCESS_MAX = 8'h5F;
    // bank that holds the upper part of the access bank (arbitrary default)
    localparam logic [5:0] ACC_HI_BANK = 6'h3F;

    // status flag bit positions
    localparam int unsigned FLG_C = 0;
    localparam int unsigned FLG_NC = 1;
    localparam int unsigned FLG_Z = 2;
    localparam int unsigned FLG_OVF = 3;
    localparam int unsigned FLG_N = 4;

    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [4:0] STAT_RST = 5'h00;
    localparam logic [13:0] PTR_RST = 14'h0000;

    // quarter-cycle phases, gray coded
    typedef enum logic [1:0] {
        PH_FIRST = 2'b00,
        PH_SECOND = 2'b01,
        PH_THIRD = 2'b11,
        PH_FOURTH = 2'b10
    } aie_phase_t;

    // decoded instruction kind
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_LIT_ACC = 2'b01,
        OP_ACC_REG = 2'b11,
        OP_LIT_PTR = 2'b10
    } aie_op_t;
endpackage

// [hw/aie_quarter_gen.sv]
// quarter-cycle enable divider and gray phase counter
`timescale 1ns/1ps
module aie_quarter_gen #(
    parameter int unsigned DIV = aie_pkg::QTR_DIV
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // quarter enable pulse and the phase it belongs to
    output logic q_en_r,
    output aie_pkg::aie_phase_t phase_r
);
    // all state of the divider
    typedef struct packed {
        logic [15:0] cnt;
        logic q_en;
        aie_pkg::aie_phase_t phase;
    } aie_qgen_t;

    aie_qgen_t st_r;
    aie_qgen_t st_nxt;

    // count core cycles, pulse once per quarter, step the phase after each pulse
    always_comb begin
        st_nxt = st_r;
        if (st_r.cnt == 16'(DIV - 1)) begin
            st_nxt.cnt = 16'h0000;
            st_nxt.q_en = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
            st_nxt.q_en = 1'b0;
        end
        if (st_r.q_en) begin
            case (st_r.phase)
                aie_pkg::PH_FIRST: st_nxt.phase = aie_pkg::PH_SECOND;
                aie_pkg::PH_SECOND: st_nxt.phase = aie_pkg::PH_THIRD;
                aie_pkg::PH_THIRD: st_nxt.phase = aie_pkg::PH_FOURTH;
                default: st_nxt.phase = aie_pkg::PH_FIRST;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '{cnt: 16'h0000, q_en: 1'b0, phase: aie_pkg::PH_FIRST};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q_en_r = st_r.q_en;
    assign phase_r = st_r.phase;
endmodule

// [hw/aie_adder8.sv]
// eight-bit adder with arithmetic status flags
`timescale 1ns/1ps
module aie_adder8 (
    // operands
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    // result and flags
    output logic [7:0] sum,
    output logic [4:0] flags
);
    logic [8:0] full; // sum with carry out of bit 7
    logic [4:0] nib; // low nibble sum with carry out of bit 3

    // plain add and flag derivation
    always_comb begin
        full = {1'b0, a} + {1'b0, b};
        nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        sum = full[7:0];
        flags = 5'h00;
        flags[aie_pkg::FLG_C] = full[8];
        flags[aie_pkg::FLG_NC] = nib[4];
        flags[aie_pkg::FLG_Z] = (full[7:0] == 8'h00);
        flags[aie_pkg::FLG_OVF] = (a[7] == b[7]) && (full[7] != a[7]);
        flags[aie_pkg::FLG_N] = full[7];
    end
endmodule

// [hw/aie_core.sv]
// add instruction execute datapath: literal, register and pointer adds
`timescale 1ns/1ps
module aie_core #(
    parameter int unsigned QDIV = aie_pkg::QTR_DIV,
    parameter logic [5:0] HI_BANK = aie_pkg::ACC_HI_BANK
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // instruction from the decoder, sampled in the first quarter
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    // addressing context
    input wire logic ext_set_en,
    input wire logic [5:0] bank_select_register,
    // data memory
    input wire logic [7:0] mem_rdata,
    output logic [13:0] mem_addr_r,
    output logic mem_rd_r,
    output logic mem_wr_r,
    output logic [7:0] mem_wdata_r,
    // architectural state
    output logic [7:0] acc_r,
    output logic [2:0][13:0] file_select_pointer_r,
    output logic [4:0] status_r,
    // sequencing
    output logic quarter_en_r,
    output aie_pkg::aie_phase_t quarter_r,
    output logic done_r,
    output aie_pkg::aie_op_t done_op_r
);
    // all state of the datapath
    typedef struct packed {
        aie_pkg::aie_op_t op;
        logic [15:0] ir;
        logic [7:0] acc;
        logic [2:0][13:0] ptr;
        logic [4:0] stat;
        logic [7:0] opnd;
        logic [7:0] sum;
        logic [4:0] flg;
        logic [13:0] psum;
        logic [13:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
        logic done;
        aie_pkg::aie_op_t done_op;
    } aie_core_t;

    aie_core_t st_r; // registered state
    aie_core_t st_nxt; // next state
    logic q_en; // quarter enable pulse
    aie_pkg::aie_phase_t phase; // current quarter
    logic [7:0] add_b; // second adder operand
    logic [7:0] add_sum; // adder result
    logic [4:0] add_flg; // adder flags
    aie_pkg::aie_op_t dec_op; // decode of the incoming word
    logic [13:0] opnd_addr; // data memory address of the register operand
    logic [7:0] f_fld; // register field of the held instruction
    logic [1:0] psel; // pointer select of the held instruction

    // quarter-cycle sequencer
    aie_quarter_gen #(
        .DIV(QDIV)
    ) u_qgen (
        .clk(clk),
        .rst_b(rst_b),
        .q_en_r(q_en),
        .phase_r(phase)
    );

    // shared adder, fed by the working register and the operand
    aie_adder8 u_add (
        .a(st_r.acc),
        .b(add_b),
        .sum(add_sum),
        .flags(add_flg)
    );

    assign f_fld = st_r.ir[7:0];
    assign psel = st_r.ir[aie_pkg::PSEL_LSB +: 2];
    // register operand comes from memory, literals from the held operand
    assign add_b = (st_r.op == aie_pkg::OP_ACC_REG) ? mem_rdata : st_r.opnd;

    // opcode decode of the incoming instruction word
    always_comb begin
        dec_op = aie_pkg::OP_NONE;
        if (instr_word[15:8] == aie_pkg::OPC_LIT_ACC) begin
            dec_op = aie_pkg::OP_LIT_ACC;
        end else if (instr_word[15:10] == aie_pkg::OPC_ACC_REG) begin
            dec_op = aie_pkg::OP_ACC_REG;
        end else if (instr_word[15:8] == aie_pkg::OPC_LIT_PTR) begin
            dec_op = aie_pkg::OP_LIT_PTR;
        end
    end

    // register operand address from the bank access bit and mode
    always_comb begin
        if (st_r.ir[aie_pkg::BANK_BIT]) begin
            opnd_addr = {bank_select_register, f_fld};
        end else if (f_fld <= aie_pkg::LOW_ACCESS_MAX) begin
            if (ext_set_en) begin
                opnd_addr = st_r.ptr[aie_pkg::IDX_PTR] + {6'h00, f_fld};
            end else begin
                opnd_addr = {6'h00, f_fld};
            end
        end else begin
            opnd_addr = {HI_BANK, f_fld};
        end
    end

    // quarter-by-quarter execution
    always_comb begin
        st_nxt = st_r;
        st_nxt.rd = 1'b0;
        st_nxt.wr = 1'b0;
        st_nxt.done = 1'b0;
        if (q_en) begin
            case (phase)
                // first quarter: take and decode the word
                aie_pkg::PH_FIRST: begin
                    st_nxt.ir = instr_word;
                    st_nxt.op = instr_valid ? dec_op : aie_pkg::OP_NONE;
                end
                // second quarter: read literal or memory register
                aie_pkg::PH_SECOND: begin
                    case (st_r.op)
                        aie_pkg::OP_ACC_REG: begin
                            st_nxt.addr = opnd_addr;
                            st_nxt.rd = 1'b1;
                        end
                        aie_pkg::OP_LIT_ACC: st_nxt.opnd = f_fld;
                        aie_pkg::OP_LIT_PTR: st_nxt.opnd = {2'b00, f_fld[5:0]};
                        default: st_nxt.opnd = st_r.opnd;
                    endcase
                end
                // third quarter: process data
                aie_pkg::PH_THIRD: begin
                    st_nxt.opnd = add_b;
                    st_nxt.sum = add_sum;
                    st_nxt.flg = add_flg;
                    if (psel != aie_pkg::PSEL_NONE) begin
                        st_nxt.psum = st_r.ptr[psel] + {8'h00, st_r.opnd[5:0]};
                    end
                end
                // fourth quarter: write destination
                default: begin
                    case (st_r.op)
                        aie_pkg::OP_LIT_ACC: begin
                            st_nxt.acc = st_r.sum;
                            st_nxt.stat = st_r.flg;
                        end
                        aie_pkg::OP_ACC_REG: begin
                            st_nxt.stat = st_r.flg;
                            if (st_r.ir[aie_pkg::DEST_BIT]) begin
                                st_nxt.wr = 1'b1;
                                st_nxt.wdata = st_r.sum;
                            end else begin
                                st_nxt.acc = st_r.sum;
                            end
                        end
                        aie_pkg::OP_LIT_PTR: begin
                            if (psel != aie_pkg::PSEL_NONE) begin
                                st_nxt.ptr[psel] = st_r.psum;
                            end
                        end
                        default: st_nxt.acc = st_r.acc;
                    endcase
                    st_nxt.done = (st_r.op != aie_pkg::OP_NONE);
                    st_nxt.done_op = st_r.op;
                    st_nxt.op = aie_pkg::OP_NONE;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '{op: aie_pkg::OP_NONE, ir: 16'h0000, acc: aie_pkg::ACC_RST,
                ptr: {3{aie_pkg::PTR_RST}}, stat: aie_pkg::STAT_RST, opnd: 8'h00,
                sum: 8'h00, flg: 5'h00, psum: 14'h0000, addr: 14'h0000, rd: 1'b0,
                wr: 1'b0, wdata: 8'h00, done: 1'b0, done_op: aie_pkg::OP_NONE};
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from state flops
    assign mem_addr_r = st_r.addr;
    assign mem_rd_r = st_r.rd;
    assign mem_wr_r = st_r.wr;
    assign mem_wdata_r = st_r.wdata;
    assign acc_r = st_r.acc;
    assign file_select_pointer_r = st_r.ptr;
    assign status_r = st_r.stat;
    assign quarter_en_r = q_en;
    assign quarter_r = phase;
    assign done_r = st_r.done;
    assign done_op_r = st_r.done_op;

    // checker helpers: values seen at decode
    logic [7:0] h_acc; // working register at decode
    logic [4:0] h_stat; // flags at decode
    logic [13:0] h_ptr; // selected pointer at decode
    logic [8:0] h_full; // expected nine-bit sum

    // capture the pre-instruction state once per instruction
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            h_acc <= 8'h00;
            h_stat <= 5'h00;
            h_ptr <= 14'h0000;
        end else if (q_en && phase == aie_pkg::PH_FIRST) begin
            h_acc <= st_r.acc;
            h_stat <= st_r.stat;
            h_ptr <= st_r.ptr[instr_word[aie_pkg::PSEL_LSB +: 2]];
        end
    end

    assign h_full = {1'b0, h_acc} + {1'b0, st_r.opnd};

    // literal add lands in the working register
    a_lit_acc_sum: assert property (@(posedge clk) disable iff (!rst_b)
        done_r && done_op_r == aie_pkg::OP_LIT_ACC |-> acc_r == h_full[7:0])
        else $error("literal add result wrong");

    // register add with d=0 writes the working register only
    a_reg_to_acc: assert property (@(posedge clk) disable iff (!rst_b)
        done_r && done_op_r == aie_pkg::OP_ACC_REG && !st_r.ir[aie_pkg::DEST_BIT]
        |-> acc_r == h_full[7:0] && !mem_wr_r)
        else $error("register add to working register wrong");

    // register add with d=1 writes memory and keeps the working register
    a_reg_to_mem: assert property (@(posedge clk) disable iff (!rst_b)
        done_r && done_op_r == aie_pkg::OP_ACC_REG && st_r.ir[aie_pkg::DEST_BIT]
        |-> mem_wr_r && mem_wdata_r == h_full[7:0] && acc_r == h_acc
            && mem_addr_r == $past(mem_addr_r))
        else $error("register add to memory wrong");

    // arithmetic adds set carry and zero from the result
    a_flags_arith: assert property (@(posedge clk) disable iff (!rst_b)
        done_r && (done_op_r == aie_pkg::OP_LIT_ACC || done_op_r == aie_pkg::OP_ACC_REG)
        |-> status_r[aie_pkg::FLG_C] == h_full[8]
            && status_r[aie_pkg::FLG_Z] == (h_full[7:0] == 8'h00)
            && status_r[aie_pkg::FLG_N] == h_full[7])
        else $error("arithmetic flags wrong");

    // pointer add updates the pointer and leaves flags alone
    a_ptr_add: assert property (@(posedge clk) disable iff (!rst_b)
        done_r && done_op_r == aie_pkg::OP_LIT_PTR && psel != aie_pkg::PSEL_NONE
        |-> file_select_pointer_r[psel] == h_ptr + {8'h00, st_r.opnd[5:0]}
            && status_r == h_stat)
        else $error("pointer add wrong");

    // results are written only in the fourth quarter
    a_write_q4: assert property (@(posedge clk) disable iff (!rst_b)
        $changed(acc_r) || $changed(file_select_pointer_r) || mem_wr_r
        |-> $past(q_en) && $past(phase) == aie_pkg::PH_FOURTH)
        else $error("write outside fourth quarter");

    // memory read is issued only in the second quarter
    a_read_q2: assert property (@(posedge clk) disable iff (!rst_b)
        mem_rd_r |-> $past(q_en) && $past(phase) == aie_pkg::PH_SECOND
            && st_r.op == aie_pkg::OP_ACC_REG)
        else $error("memory read outside second quarter");

    // banked operand addressing
    a_bank_addr: assert property (@(posedge clk) disable iff (!rst_b)
        mem_rd_r && st_r.ir[aie_pkg::BANK_BIT]
        |-> mem_addr_r == {$past(bank_select_register), f_fld})
        else $error("banked address wrong");

    // indexed literal offset addressing
    a_indexed_addr: assert property (@(posedge clk) disable iff (!rst_b)
        mem_rd_r && !st_r.ir[aie_pkg::BANK_BIT] && $past(ext_set_en)
            && f_fld <= aie_pkg::LOW_ACCESS_MAX
        |-> mem_addr_r == st_r.ptr[aie_pkg::IDX_PTR] + {6'h00, f_fld})
        else $error("indexed address wrong");

    // a valid literal add word decodes to the literal add
    a_decode_lit: assert property (@(posedge clk) disable iff (!rst_b)
        q_en && phase == aie_pkg::PH_FIRST && instr_valid
            && instr_word[15:8] == aie_pkg::OPC_LIT_ACC
        |=> st_r.op == aie_pkg::OP_LIT_ACC)
        else $error("literal add not decoded");

    // main scenarios
    c_lit_acc: cover property (@(posedge clk) disable iff (!rst_b)
        done_r && done_op_r == aie_pkg::OP_LIT_ACC);
    c_reg_mem: cover property (@(posedge clk) disable iff (!rst_b)
        done_r && done_op_r == aie_pkg::OP_ACC_REG && mem_wr_r);
    c_ptr_add: cover property (@(posedge clk) disable iff (!rst_b)
        done_r && done_op_r == aie_pkg::OP_LIT_PTR);
    c_overflow: cover property (@(posedge clk) disable iff (!rst_b)
        done_r && status_r[aie_pkg::FLG_OVF]);
endmodule

// [dv/aie_mem_model.sv]
// banked data memory model that answers the add block's read and write strobes
`timescale 1ns/1ps
module aie_mem_model (
    // clock
    input wire logic clk,
    // request from the add block
    input wire logic [13:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    // answer to the add block
    output logic [7:0] mem_rdata
);
    // storage, preloaded by the bench through the hierarchy
    logic [7:0] mem [0:16383];

    // clear the whole array so no read ever returns an unknown
    initial begin
        for (int i = 0; i < 16384; i++) begin
            mem[i] = 8'h00;
        end
    end

    // read is combinational; outside a read the bus shows the inverse, never a stale value
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];

    // write lands on the edge that ends the write strobe cycle
    always @(posedge clk) begin
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule

// [dv/add_instruction_execute_tb.sv]
// self-checking bench for the add instruction execute block
`timescale 1ns/1ps
module add_instruction_execute_tb;
    // design ports
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic ext_set_en = 1'b0;
    logic [5:0] bank_select_register = 6'h00;
    logic [7:0] mem_rdata;
    logic [13:0] mem_addr_r;
    logic mem_rd_r, mem_wr_r;
    logic [7:0] mem_wdata_r, acc_r;
    logic [2:0][13:0] file_select_pointer_r;
    logic [4:0] status_r;
    logic quarter_en_r, done_r;
    aie_pkg::aie_phase_t quarter_r;
    aie_pkg::aie_op_t done_op_r;
    // bench bookkeeping
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    int done_at, rd_at, wr_at;
    logic [13:0] rd_addr;
    aie_pkg::aie_op_t op_seen;
    // expected architectural state
    logic [7:0] acc_m = 8'h00;
    logic [4:0] stat_m = 5'h00;
    logic [13:0] ptr_m [3] = '{14'h0000, 14'h0000, 14'h0000};

    // design under test with default quarter divider
    aie_core dut (
        .clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr_word(instr_word),
        .ext_set_en(ext_set_en), .bank_select_register(bank_select_register),
        .mem_rdata(mem_rdata), .mem_addr_r(mem_addr_r), .mem_rd_r(mem_rd_r),
        .mem_wr_r(mem_wr_r), .mem_wdata_r(mem_wdata_r), .acc_r(acc_r),
        .file_select_pointer_r(file_select_pointer_r), .status_r(status_r),
        .quarter_en_r(quarter_en_r), .quarter_r(quarter_r), .done_r(done_r),
        .done_op_r(done_op_r)
    );

    // far-side data memory
    aie_mem_model mem_i (
        .clk(clk), .mem_addr(mem_addr_r), .mem_rd(mem_rd_r), .mem_wr(mem_wr_r),
        .mem_wdata(mem_wdata_r), .mem_rdata(mem_rdata)
    );

    // 50 MHz core clock
    always #10 clk = ~clk;

    // hang guard, far above the roughly 110 cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            stop_test();
        end
    end

    // counts and final verdict
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one comparison
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, msg, got, exp);
        end
    endtask

    // reference add: flags in the package's bit order above the sum
    function automatic logic [12:0] add_ref(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        logic [4:0] h;
        logic [4:0] f;
        s = {1'b0, a} + {1'b0, b};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        f = 5'h00;
        f[aie_pkg::FLG_C] = s[8];
        f[aie_pkg::FLG_NC] = h[4];
        f[aie_pkg::FLG_Z] = (s[7:0] == 8'h00);
        f[aie_pkg::FLG_OVF] = (a[7] == b[7]) && (s[7] != a[7]);
        f[aie_pkg::FLG_N] = s[7];
        return {f, s[7:0]};
    endfunction

    // present one word on a first-quarter pulse and log strobes and completion
    task automatic issue(input logic v, input logic [15:0] w);
        int n;
        aie_pkg::aie_phase_t ph1; // phase seen in the cycle after the decode pulse
        n = 0;
        while (!(quarter_en_r === 1'b1 && quarter_r === aie_pkg::PH_FIRST) && n < 8) begin
            @(negedge clk);
            n++;
        end
        chk(16'(n < 8), 16'd1, "first quarter pulse found");
        instr_valid = v;
        instr_word = w;
        done_at = 0;
        rd_at = 0;
        wr_at = 0;
        for (int i = 1; i <= 6 && done_at == 0; i++) begin
            @(negedge clk);
            // drop valid once only, so a back-to-back call owns this time step
            if (i == 1) begin
                instr_valid = 1'b0;
                ph1 = quarter_r;
            end
            if (mem_rd_r === 1'b1) begin
                rd_at = i;
                rd_addr = mem_addr_r;
            end
            if (mem_wr_r === 1'b1) wr_at = i;
            if (done_r === 1'b1) begin
                done_at = i;
                op_seen = done_op_r;
            end
        end
        chk(16'(ph1), 16'(aie_pkg::PH_SECOND), "second quarter follows decode");
    endtask

    // literal add into the working register
    task automatic lit_add(input logic [7:0] k);
        logic [12:0] e;
        e = add_ref(acc_m, k);
        issue(1'b1, {aie_pkg::OPC_LIT_ACC, k});
        chk(16'(done_at), 16'd4, "literal add latency");
        chk(16'(op_seen), 16'(aie_pkg::OP_LIT_ACC), "literal add kind");
        chk(16'(acc_r), 16'(e[7:0]), "literal add sum");
        chk(16'(status_r), 16'(e[12:8]), "literal add flags");
        acc_m = e[7:0];
        stat_m = e[12:8];
    endtask

    // register add with destination, bank access, context and expected address
    task automatic reg_add(input logic d, input logic a, input logic [7:0] f,
                           input logic [5:0] bank, input logic ext,
                           input logic [13:0] addr, input logic [7:0] mval);
        logic [12:0] e;
        bank_select_register = bank;
        ext_set_en = ext;
        mem_i.mem[addr] = mval;
        e = add_ref(acc_m, mval);
        issue(1'b1, {aie_pkg::OPC_ACC_REG, d, a, f});
        chk(16'(rd_at), 16'd2, "read quarter");
        chk(16'(rd_addr), 16'(addr), "operand address");
        chk(16'(done_at), 16'd4, "register add latency");
        chk(16'(op_seen), 16'(aie_pkg::OP_ACC_REG), "register add kind");
        chk(16'(status_r), 16'(e[12:8]), "register add flags");
        stat_m = e[12:8];
        if (d) begin
            chk(16'(wr_at), 16'd4, "write quarter");
            chk(16'(acc_r), 16'(acc_m), "working register kept");
            @(negedge clk);
            chk(16'(mem_i.mem[addr]), 16'(e[7:0]), "memory sum");
        end else begin
            chk(16'(wr_at), 16'd0, "no memory write");
            chk(16'(acc_r), 16'(e[7:0]), "register add sum");
            acc_m = e[7:0];
        end
    endtask

    // literal add into a pointer; select 3 leaves all pointers alone
    task automatic ptr_add(input logic [1:0] sel, input logic [5:0] k);
        issue(1'b1, {aie_pkg::OPC_LIT_PTR, sel, k});
        if (sel != aie_pkg::PSEL_NONE) ptr_m[sel] = ptr_m[sel] + 14'(k);
        chk(16'(done_at), 16'd4, "pointer add latency");
        chk(16'(op_seen), 16'(aie_pkg::OP_LIT_PTR), "pointer add kind");
        for (int i = 0; i < 3; i++) begin
            chk(16'(file_select_pointer_r[i]), 16'(ptr_m[i]), "pointer value");
        end
        chk(16'(status_r), 16'(stat_m), "flags kept by pointer add");
    endtask

    // literal adds reaching every flag: plain, nibble carry, overflow, carry and zero
    task automatic t_literal();
        lit_add(8'h10);
        lit_add(8'h15);
        lit_add(8'h5B);
        lit_add(8'h80);
        lit_add(8'h0F);
        $display("literal add test done");
    endtask

    // pointer adds on each select, the idle select and the largest literal
    task automatic t_pointer();
        ptr_add(2'h2, 6'h3F);
        ptr_add(2'h0, 6'h01);
        ptr_add(2'h1, 6'h20);
        ptr_add(2'h3, 6'h3F);
        ptr_add(2'h2, 6'h3F);
        $display("pointer add test done");
    endtask

    // register adds over both destinations and every addressing mode
    task automatic t_register();
        reg_add(1'b0, 1'b1, 8'h34, 6'h05, 1'b0, 14'h0534, 8'hC2);
        reg_add(1'b1, 1'b0, 8'h20, 6'h05, 1'b0, 14'h0020, 8'h7F);
        reg_add(1'b1, 1'b0, 8'hA0, 6'h05, 1'b0, {aie_pkg::ACC_HI_BANK, 8'hA0}, 8'h01);
        reg_add(1'b0, 1'b0, 8'h10, 6'h05, 1'b1, ptr_m[2] + 14'h0010, 8'h33);
        reg_add(1'b1, 1'b0, 8'h5F, 6'h05, 1'b1, ptr_m[2] + 14'h005F, 8'h80);
        reg_add(1'b1, 1'b0, 8'h60, 6'h05, 1'b1, {aie_pkg::ACC_HI_BANK, 8'h60}, 8'h80);
        reg_add(1'b1, 1'b1, 8'h10, 6'h2A, 1'b1, 14'h2A10, 8'h44);
        $display("register add test done");
    endtask

    // words that must not execute: not valid, and a foreign opcode
    task automatic t_refused();
        issue(1'b0, {aie_pkg::OPC_LIT_ACC, 8'h01});
        chk(16'(done_at), 16'd0, "idle word completed");
        issue(1'b1, 16'h0B12);
        chk(16'(done_at), 16'd0, "foreign word completed");
        chk(16'(acc_r), 16'(acc_m), "working register disturbed");
        chk(16'(status_r), 16'(stat_m), "flags disturbed");
        $display("refusal test done");
    endtask

    // main sequence
    initial begin
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        t_literal();
        t_pointer();
        t_register();
        t_refused();
        stop_test();
    end
endmodule
